/* dac_output_gain_stage_consts.svh */
`ifndef DAC_OUTPUT_GAIN_STAGE_CONSTS_SVH
`define DAC_OUTPUT_GAIN_STAGE_CONSTS_SVH
// What this block does
// R1: Bypass set: PCM passes, DSD is halved.
// R2: Bypass clear: add squared and cubed terms.
// R3: Second-order coefficient: signed, high byte higher.
// R4: Third-order coefficient: signed, high byte higher.
// R5: Software writes reserved control bits as zero.
// R6: Unity gain: bypass clear, coefficients zero.
// R7: Ramp-target bit picks ground or half supply.
// R8: Optional force-low when input lock is lost.
// R9: Optional forced mute when lock is lost.
// R10: Ramp lasts 4096 times two-power (field+1) cycles.
// R11: Software keeps ramp field from 0 to 20.
// R12: Attenuation 0 to 127.5 dB, half-dB steps.
// R13: Attenuation registers follow the channel swap.
// R14: Full-scale trim: four bytes, highest is MSB.
// R15: Signed trim sets 0 dB, resets maximum positive.
// R16: Lock after programmable count of frame-clock edges.
// R17: Each attenuation code step adds 0.5 dB.
// R18: Compensation saturates instead of wrapping.

`define COMP_CTRL_OFFSET     8'h0D
`define RAMP_SET_OFFSET      8'h0E
`define ATTEN_A_OFFSET       8'h0F
`define ATTEN_B_OFFSET       8'h10
`define TRIM_B0_OFFSET       8'h11
`define TRIM_B1_OFFSET       8'h12
`define TRIM_B2_OFFSET       8'h13
`define TRIM_B3_OFFSET       8'h14
`define COEF2_LO_OFFSET      8'h16
`define COEF2_HI_OFFSET      8'h17
`define COEF3_LO_OFFSET      8'h18
`define COEF3_HI_OFFSET      8'h19

`define COMP_CTRL_RESET      8'h40
`define RAMP_SET_RESET       8'h8A
`define ATTEN_RESET          8'h00
`define TRIM_RESET           32'h7FFFFFFF
`define COEF_RESET           16'h0000

`define COMP_BYPASS_BIT      6
`define RAMP_TARGET_BIT      7
`define FORCE_LOW_BIT        6
`define MUTE_ON_LOSS_BIT     5
`define RAMP_TIME_MSB        4
`define RAMP_TIME_MAX        5'h14

`define RAMP_BASE_LOG2       13
`define RAMP_ACC_FULL        35'h400000000
`define LOCK_EDGES_MAX       16384
`define ATTEN_STEPS_PER_SHIFT 12
`endif

/* dac_output_gain_stage_pkg.sv */
package dac_output_gain_stage_pkg;
  typedef logic signed [31:0] sample_type;
  typedef logic signed [15:0] coeff_type;
  typedef enum logic [3:0] {
    RAMP_LOW  = 4'b0001,
    RAMP_UP   = 4'b0010,
    RAMP_HIGH = 4'b0100,
    RAMP_DOWN = 4'b1000
  } ramp_state_type;
endpackage : dac_output_gain_stage_pkg

/* gain_path_if.sv */
interface gain_path_if;
  import dac_output_gain_stage_pkg::*;
  logic       in_valid;
  sample_type in_sample;
  logic       dsd;
  logic       bypass;
  coeff_type  coef2;
  coeff_type  coef3;
  sample_type trim;
  logic [7:0] atten;
  logic       out_valid;
  sample_type out_sample;
  modport feeder (output in_valid, in_sample, dsd, bypass, coef2, coef3, trim, atten,
                  input out_valid, out_sample);
  modport stage  (input in_valid, in_sample, dsd, bypass, coef2, coef3, trim, atten,
                  output out_valid, out_sample);
endinterface : gain_path_if

/* channel_gain_path.sv */
`include "dac_output_gain_stage_consts.svh"
module channel_gain_path (
  input  wire logic  ref_clk, // Master clock.
  input  wire logic  rst_n,   // Synchronous reset, active low.
  gain_path_if.stage path     // Sample in, settings, sample out.
);
  import dac_output_gain_stage_pkg::*;

  function automatic sample_type sat32(input logic signed [49:0] v);
    if (v > 50'sh0007FFFFFFF)
      sat32 = 32'sh7FFFFFFF;
    else if (v < -50'sh00080000000)
      sat32 = 32'sh80000000;
    else
      sat32 = v[31:0];
  endfunction : sat32

  // Gain of 10^(-r/40) for the sub-6 dB remainder, unity at 2^15.
  function automatic logic [16:0] fine_gain(input logic [3:0] r);
    case (r)
      4'h0:    fine_gain = 17'h08000;
      4'h1:    fine_gain = 17'h078D7;
      4'h2:    fine_gain = 17'h07215;
      4'h3:    fine_gain = 17'h06BB3;
      4'h4:    fine_gain = 17'h065AD;
      4'h5:    fine_gain = 17'h05FFD;
      4'h6:    fine_gain = 17'h05A9E;
      4'h7:    fine_gain = 17'h0558C;
      4'h8:    fine_gain = 17'h050C3;
      4'h9:    fine_gain = 17'h04C3F;
      4'hA:    fine_gain = 17'h047FB;
      4'hB:    fine_gain = 17'h043F4;
      default: fine_gain = 17'h08000;
    endcase
  endfunction : fine_gain

  wire logic signed [63:0] sq_full   = path.in_sample * path.in_sample;
  wire logic signed [31:0] sq_q      = sq_full[62:31];
  wire logic signed [63:0] cube_full = sq_q * path.in_sample;
  wire logic signed [31:0] cube_q    = cube_full[62:31];
  wire logic signed [47:0] term2     = sq_q * path.coef2;
  wire logic signed [47:0] term3     = cube_q * path.coef3;
  wire logic signed [49:0] poly_sum  = 50'(path.in_sample) + 50'(term2 >>> 15) + 50'(term3 >>> 15);
  wire sample_type comp_next = path.bypass ?
    (path.dsd ? (path.in_sample >>> 1) : path.in_sample) : // R1
    sat32(poly_sum); // R2 R18

  sample_type comp_reg;
  sample_type trim_reg;
  sample_type out_reg;
  logic [2:0] valid_reg;

  // The trim is treated as a Q1.31 factor, so its reset value is just below unity.
  wire logic signed [63:0] trim_full  = comp_reg * path.trim; // R15
  wire logic [4:0]         coarse     = 5'(path.atten / `ATTEN_STEPS_PER_SHIFT); // R17
  wire logic [3:0]         fine_idx   = 4'(path.atten % `ATTEN_STEPS_PER_SHIFT);
  wire sample_type         coarse_q   = trim_reg >>> coarse;
  // A shift stands for 6.02 dB; the error grows to about 0.43 dB at full depth (21 shifts).
  wire logic signed [49:0] atten_full = coarse_q * $signed({1'b0, fine_gain(fine_idx)}); // R12 R17
  wire sample_type         atten_next = atten_full[46:15];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      comp_reg  <= 32'sh00000000;
      trim_reg  <= 32'sh00000000;
      out_reg   <= 32'sh00000000;
      valid_reg <= 3'h0;
    end else begin
      comp_reg  <= comp_next;
      trim_reg  <= trim_full[62:31];
      out_reg   <= atten_next;
      valid_reg <= {valid_reg[1:0], path.in_valid};
    end
  end

  assign path.out_sample = out_reg;
  assign path.out_valid  = valid_reg[2];
endmodule : channel_gain_path

/* dac_output_gain_stage.sv */
`include "dac_output_gain_stage_consts.svh"
module dac_output_gain_stage (
  input  wire logic                             ref_clk,        // Master clock, 100 MHz.
  input  wire logic                             rst_n,          // Synchronous reset, active low.
  input  wire logic                             reg_we,         // Register write strobe.
  input  wire logic [7:0]                       reg_addr,       // Register number.
  input  wire logic [7:0]                       reg_wdata,      // Register write byte.
  output logic [7:0]                            reg_rdata,      // Register read byte, one cycle later.
  input  wire logic                             frame_rate_clock, // Frame-rate clock pin.
  input  wire logic                             input_present,  // Decoder sees a valid stream.
  input  wire logic [3:0]                       lock_edge_sel,  // Lock edge count select.
  input  wire logic                             channel_swap,   // Channel mapping swaps A and B.
  input  wire logic                             dsd_mode,       // Stream is DSD, not PCM.
  input  wire logic                             in_valid,       // Input sample pair strobe.
  input  dac_output_gain_stage_pkg::sample_type in_left,        // Left input sample.
  input  dac_output_gain_stage_pkg::sample_type in_right,       // Right input sample.
  output logic                                  out_valid,      // Output sample pair strobe.
  output dac_output_gain_stage_pkg::sample_type out_left,       // Left output sample.
  output dac_output_gain_stage_pkg::sample_type out_right,      // Right output sample.
  output logic                                  locked,         // Input lock held.
  output logic                                  muted,          // Mute forced by lock loss.
  output logic                                  ramp_busy,      // Soft-start ramp in motion.
  output logic [16:0]                           ramp_level      // Ramp gain, unity at 2^16.
);
  import dac_output_gain_stage_pkg::*;

  // Register storage.
  logic [7:0]  comp_ctrl_reg;
  logic [7:0]  ramp_set_reg;
  logic [7:0]  atten_a_reg;
  logic [7:0]  atten_b_reg;
  logic [31:0] trim_reg;
  logic [15:0] coef2_reg;
  logic [15:0] coef3_reg;
  logic [7:0]  rdata_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic wr_comp  = reg_we && hit(reg_addr, `COMP_CTRL_OFFSET);
  wire logic wr_ramp  = reg_we && hit(reg_addr, `RAMP_SET_OFFSET);
  wire logic wr_att_a = reg_we && hit(reg_addr, `ATTEN_A_OFFSET);
  wire logic wr_att_b = reg_we && hit(reg_addr, `ATTEN_B_OFFSET);
  wire logic [3:0] wr_trim = {4{reg_we}} & {hit(reg_addr, `TRIM_B3_OFFSET), hit(reg_addr, `TRIM_B2_OFFSET),
                                            hit(reg_addr, `TRIM_B1_OFFSET), hit(reg_addr, `TRIM_B0_OFFSET)};
  wire logic [1:0] wr_c2 = {2{reg_we}} & {hit(reg_addr, `COEF2_HI_OFFSET), hit(reg_addr, `COEF2_LO_OFFSET)};
  wire logic [1:0] wr_c3 = {2{reg_we}} & {hit(reg_addr, `COEF3_HI_OFFSET), hit(reg_addr, `COEF3_LO_OFFSET)};

  // Reserved control bits are stored as written; only the bypass bit acts.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      comp_ctrl_reg <= `COMP_CTRL_RESET;
      ramp_set_reg  <= `RAMP_SET_RESET;
      atten_a_reg   <= `ATTEN_RESET;
      atten_b_reg   <= `ATTEN_RESET;
    end else begin
      if (wr_comp)
        comp_ctrl_reg <= reg_wdata;
      if (wr_ramp)
        ramp_set_reg <= reg_wdata;
      if (wr_att_a)
        atten_a_reg <= reg_wdata;
      if (wr_att_b)
        atten_b_reg <= reg_wdata;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_trim_byte
      always_ff @(posedge ref_clk) begin
        if (!rst_n)
          trim_reg[gb*8 +: 8] <= 8'(`TRIM_RESET >> (gb*8)); // R15
        else if (wr_trim[gb])
          trim_reg[gb*8 +: 8] <= reg_wdata; // R14
      end
    end
    for (gb = 0; gb < 2; gb++) begin : g_coef_byte
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          coef2_reg[gb*8 +: 8] <= 8'(`COEF_RESET >> (gb*8));
          coef3_reg[gb*8 +: 8] <= 8'(`COEF_RESET >> (gb*8));
        end else begin
          if (wr_c2[gb])
            coef2_reg[gb*8 +: 8] <= reg_wdata; // R3
          if (wr_c3[gb])
            coef3_reg[gb*8 +: 8] <= reg_wdata; // R4
        end
      end
    end
  endgenerate

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `COMP_CTRL_OFFSET: rd_mux = comp_ctrl_reg;
      `RAMP_SET_OFFSET:  rd_mux = ramp_set_reg;
      `ATTEN_A_OFFSET:   rd_mux = atten_a_reg;
      `ATTEN_B_OFFSET:   rd_mux = atten_b_reg;
      `TRIM_B0_OFFSET:   rd_mux = trim_reg[7:0];
      `TRIM_B1_OFFSET:   rd_mux = trim_reg[15:8];
      `TRIM_B2_OFFSET:   rd_mux = trim_reg[23:16];
      `TRIM_B3_OFFSET:   rd_mux = trim_reg[31:24];
      `COEF2_LO_OFFSET:  rd_mux = coef2_reg[7:0];
      `COEF2_HI_OFFSET:  rd_mux = coef2_reg[15:8];
      `COEF3_LO_OFFSET:  rd_mux = coef3_reg[7:0];
      `COEF3_HI_OFFSET:  rd_mux = coef3_reg[15:8];
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_mux;
  end

  // Lock detection on the frame-rate clock pin.
  logic        frc_meta_reg;
  logic        frc_sync_reg;
  logic        frc_prev_reg;
  logic [14:0] edge_cnt_reg;
  logic        lock_reg;

  function automatic logic [14:0] lock_target(input logic [3:0] sel);
    lock_target = 15'(`LOCK_EDGES_MAX);
    for (int i = 0; i < 16; i++) begin
      if (sel == 4'(i))
        lock_target = 15'(`LOCK_EDGES_MAX / (i + 1));
    end
  endfunction : lock_target

  wire logic frc_rise    = frc_sync_reg && !frc_prev_reg;
  wire logic edges_done  = (edge_cnt_reg >= lock_target(lock_edge_sel));
  wire logic lock_lost   = !lock_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frc_meta_reg <= 1'b0;
      frc_sync_reg <= 1'b0;
      frc_prev_reg <= 1'b0;
      edge_cnt_reg <= 15'h0000;
      lock_reg     <= 1'b0;
    end else begin
      frc_meta_reg <= frame_rate_clock;
      frc_sync_reg <= frc_meta_reg;
      frc_prev_reg <= frc_sync_reg;
      if (!input_present) begin
        edge_cnt_reg <= 15'h0000;
        lock_reg     <= 1'b0;
      end else begin
        if (frc_rise && !edges_done)
          edge_cnt_reg <= edge_cnt_reg + 15'h0001; // R16
        lock_reg <= edges_done; // R16
      end
    end
  end

  // Soft-start ramp.
  ramp_state_type state_reg;
  ramp_state_type state_next;
  logic [34:0]    acc_reg;
  logic [34:0]    acc_next;

  wire logic [4:0]  ramp_time  = (ramp_set_reg[`RAMP_TIME_MSB:0] > `RAMP_TIME_MAX) ?
                                 `RAMP_TIME_MAX : ramp_set_reg[`RAMP_TIME_MSB:0];
  // Full scale is 2^34, so a step of 2^(21-t) spans 2^(t+13) cycles.
  wire logic [34:0] ramp_step  = 35'h1 << (5'(34 - `RAMP_BASE_LOG2) - ramp_time); // R10
  wire logic        force_low  = ramp_set_reg[`FORCE_LOW_BIT] && lock_lost; // R8
  wire logic        go_high    = ramp_set_reg[`RAMP_TARGET_BIT] && !force_low; // R7
  wire logic        force_mute = ramp_set_reg[`MUTE_ON_LOSS_BIT] && lock_lost; // R9
  wire logic        acc_top    = (acc_reg >= `RAMP_ACC_FULL - ramp_step);
  wire logic        acc_bottom = (acc_reg <= ramp_step);

  always_comb begin
    state_next = state_reg;
    acc_next   = acc_reg;
    case (state_reg)
      RAMP_LOW: begin
        acc_next = 35'h0;
        if (go_high)
          state_next = RAMP_UP;
      end
      RAMP_UP: begin
        if (!go_high) begin
          state_next = RAMP_DOWN;
        end else if (acc_top) begin
          acc_next   = `RAMP_ACC_FULL;
          state_next = RAMP_HIGH;
        end else begin
          acc_next = acc_reg + ramp_step; // R10
        end
      end
      RAMP_HIGH: begin
        acc_next = `RAMP_ACC_FULL;
        if (!go_high)
          state_next = RAMP_DOWN;
      end
      RAMP_DOWN: begin
        if (go_high) begin
          state_next = RAMP_UP;
        end else if (acc_bottom) begin
          acc_next   = 35'h0;
          state_next = RAMP_LOW;
        end else begin
          acc_next = acc_reg - ramp_step; // R7
        end
      end
      default: begin
        acc_next   = 35'h0;
        state_next = RAMP_LOW;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= RAMP_LOW;
      acc_reg   <= 35'h0;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
    end
  end

  wire logic [16:0] ramp_gain = acc_reg[34:18];

  // Two channel paths; attenuation registers follow the channel mapping.
  gain_path_if path_a ();
  gain_path_if path_b ();
  wire logic [7:0] atten_left  = channel_swap ? atten_b_reg : atten_a_reg; // R13
  wire logic [7:0] atten_right = channel_swap ? atten_a_reg : atten_b_reg; // R13

  assign path_a.in_valid  = in_valid;
  assign path_a.in_sample = in_left;
  assign path_a.dsd       = dsd_mode;
  assign path_a.bypass    = comp_ctrl_reg[`COMP_BYPASS_BIT]; // R1
  assign path_a.coef2     = coef2_reg;
  assign path_a.coef3     = coef3_reg;
  assign path_a.trim      = trim_reg;
  assign path_a.atten     = atten_left;
  assign path_b.in_valid  = in_valid;
  assign path_b.in_sample = in_right;
  assign path_b.dsd       = dsd_mode;
  assign path_b.bypass    = comp_ctrl_reg[`COMP_BYPASS_BIT]; // R1
  assign path_b.coef2     = coef2_reg;
  assign path_b.coef3     = coef3_reg;
  assign path_b.trim      = trim_reg;
  assign path_b.atten     = atten_right;

  channel_gain_path u_path_left (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .path    (path_a.stage)
  );

  channel_gain_path u_path_right (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .path    (path_b.stage)
  );

  // Ramp gain applied last so a lock loss silences even a full-scale trim.
  wire logic signed [49:0] left_full  = path_a.out_sample * $signed({1'b0, ramp_gain});
  wire logic signed [49:0] right_full = path_b.out_sample * $signed({1'b0, ramp_gain});

  sample_type out_left_reg;
  sample_type out_right_reg;
  logic       out_valid_reg;
  logic       muted_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_left_reg  <= 32'sh00000000;
      out_right_reg <= 32'sh00000000;
      out_valid_reg <= 1'b0;
      muted_reg     <= 1'b0;
    end else begin
      out_valid_reg <= path_a.out_valid;
      muted_reg     <= force_mute;
      if (force_mute) begin
        out_left_reg  <= 32'sh00000000; // R9
        out_right_reg <= 32'sh00000000; // R9
      end else begin
        out_left_reg  <= left_full[47:16];
        out_right_reg <= right_full[47:16];
      end
    end
  end

  logic       busy_reg;
  logic [16:0] level_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg  <= 1'b0;
      level_reg <= 17'h00000;
    end else begin
      busy_reg  <= (state_reg == RAMP_UP) || (state_reg == RAMP_DOWN);
      level_reg <= ramp_gain;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign out_valid  = out_valid_reg;
  assign out_left   = out_left_reg;
  assign out_right  = out_right_reg;
  assign locked     = lock_reg;
  assign muted      = muted_reg;
  assign ramp_busy  = busy_reg;
  assign ramp_level = level_reg;
endmodule : dac_output_gain_stage

/* dac_output_gain_stage_monitor.sv */
`include "dac_output_gain_stage_consts.svh"
module dac_output_gain_stage_monitor (
  input wire logic                             ref_clk,       // Clock.
  input wire logic                             rst_n,         // Reset.
  input wire logic                             reg_we,        // Write.
  input wire logic [7:0]                       reg_addr,      // Address.
  input wire logic [7:0]                       reg_wdata,     // Write byte.
  input wire logic [7:0]                       reg_rdata,     // Read byte.
  input wire logic                             input_present, // Stream valid.
  input wire logic                             in_valid,      // In strobe.
  input wire logic                             out_valid,     // Out strobe.
  input dac_output_gain_stage_pkg::sample_type out_left,      // Left out.
  input dac_output_gain_stage_pkg::sample_type out_right,     // Right out.
  input wire logic                             locked,        // Lock.
  input wire logic                             muted,         // Mute.
  input wire logic [16:0]                      ramp_level     // Ramp gain.
);
  import dac_output_gain_stage_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    in_valid;
  endsequence
  sequence s_answered;
    ##4 out_valid;
  endsequence
  sequence s_absent;
    !input_present ##1 !input_present;
  endsequence
  sequence s_atten_write;
    reg_we && reg_addr == `ATTEN_A_OFFSET ##1 !reg_we && reg_addr == `ATTEN_A_OFFSET;
  endsequence
  property p_latency;
    s_taken |-> s_answered;
  endproperty
  property p_no_spurious;
    out_valid |-> $past(in_valid, 4);
  endproperty
  // One cycle of slack, since the mute flag may trail the lock flag by a register.
  property p_mute_cause;
    muted |-> !locked || !$past(locked);
  endproperty
  property p_mute_zero;
    muted && out_valid |-> out_left == '0 && out_right == '0;
  endproperty
  property p_ramp_max;
    ramp_level <= 17'h10000;
  endproperty
  // The fastest ramp moves eight gain units per cycle; a jump means a broken accumulator.
  property p_ramp_step;
    ramp_level <= $past(ramp_level) + 17'h8 && $past(ramp_level) <= ramp_level + 17'h8;
  endproperty
  property p_lock_clear;
    s_absent |=> !locked;
  endproperty
  property p_readback;
    s_atten_write |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_latency: assert property (p_latency)
    else $error("Output strobe missing four cycles after input.");
  a_no_spurious: assert property (p_no_spurious)
    else $error("Output strobe without input.");
  a_mute_cause: assert property (p_mute_cause)
    else $error("Mute while locked.");
  a_mute_zero: assert property (p_mute_zero)
    else $error("Muted output not zero.");
  a_ramp_max: assert property (p_ramp_max)
    else $error("Ramp gain above unity.");
  a_ramp_step: assert property (p_ramp_step)
    else $error("Ramp gain jumped.");
  a_lock_clear: assert property (p_lock_clear)
    else $error("Lock held without input.");
  a_readback: assert property (p_readback)
    else $error("Attenuation readback wrong.");
endmodule : dac_output_gain_stage_monitor
bind dac_output_gain_stage dac_output_gain_stage_monitor u_dac_output_gain_stage_monitor (.ref_clk, .rst_n,
  .reg_we, .reg_addr, .reg_wdata, .reg_rdata, .input_present, .in_valid, .out_valid, .out_left, .out_right,
  .locked, .muted, .ramp_level);

/* dac_output_gain_stage_tb_top.sv */
`include "dac_output_gain_stage_consts.svh"
module dac_output_gain_stage_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dac_output_gain_stage_pkg::*;
  logic        ref_clk       = 1'b0;
  logic        rst_n         = 1'b0;
  logic        reg_we        = 1'b0;
  logic [7:0]  reg_addr      = 8'h00;
  logic [7:0]  reg_wdata     = 8'h00;
  logic [7:0]  reg_rdata;
  logic [1:0]  frc_count     = 2'b00;
  logic        frc_run       = 1'b0;
  wire         frame_rate_clock = frc_count[1];
  logic        input_present = 1'b0;
  logic [3:0]  lock_edge_sel = 4'hF;
  logic        channel_swap  = 1'b0;
  logic        dsd_mode      = 1'b0;
  logic        in_valid      = 1'b0;
  sample_type  in_left       = '0;
  sample_type  in_right      = '0;
  logic        out_valid;
  sample_type  out_left;
  sample_type  out_right;
  logic        locked;
  logic        muted;
  logic        ramp_busy;
  logic [16:0] ramp_level;
  int          mismatches    = 0;
  int          n_compared    = 0;
  const sample_type x = 32'h40000000;
  const sample_type y = 32'hC0000001;
  const sample_type g = `TRIM_RESET;

  dac_output_gain_stage u_dac_output_gain_stage (.ref_clk, .rst_n, .reg_we, .reg_addr, .reg_wdata,
    .reg_rdata, .frame_rate_clock, .input_present, .lock_edge_sel, .channel_swap, .dsd_mode, .in_valid,
    .in_left, .in_right, .out_valid, .out_left, .out_right, .locked, .muted, .ramp_busy, .ramp_level);

  always #5 ref_clk = ~ref_clk;
  // The frame clock rises every fourth cycle, so 1024 edges take about 4100 cycles.
  always @(posedge ref_clk) begin
    #1;
    if (frc_run) frc_count = frc_count + 2'b01;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  function automatic sample_type scl(input sample_type v, input sample_type k);
    logic signed [63:0] p;
    p = 64'(v) * 64'(k);
    return p[62:31];
  endfunction : scl
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(posedge ref_clk) #1;
    reg_we = 1'b0;
    // A quiet cycle keeps back-to-back writes from toggling the strobe in one time step.
    @(posedge ref_clk) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    @(posedge ref_clk) #1;
    d = reg_rdata;
  endtask : rd
  task automatic send(input sample_type l, input sample_type r, input sample_type el, input sample_type er);
    in_left = l;
    in_right = r;
    in_valid = 1'b1;
    @(posedge ref_clk) #1;
    in_valid = 1'b0;
    repeat (3) @(posedge ref_clk) #1;
    check(out_valid, 1'b1);
    check(out_left, el);
    check(out_right, er);
  endtask : send
  // The busy flag trails the state by a cycle, so the count starts three cycles late.
  task automatic settle(output int n);
    n = 3;
    repeat (3) @(posedge ref_clk) #1;
    while (ramp_busy === 1'b1 && n < 20000) begin
      @(posedge ref_clk) #1;
      n++;
    end
  endtask : settle

  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] e;
    for (int a = 12; a <= 26; a++) begin
      rd(8'(a), d);
      case (a)
        13: e = 8'h40;
        14: e = 8'h8A;
        17, 18, 19: e = 8'hFF;
        20: e = 8'h7F;
        default: e = 8'h00;
      endcase
      check(d, e);
    end
  endtask : t_regs
  task automatic t_ramp;
    int n;
    wr(`RAMP_SET_OFFSET, 8'h00);
    settle(n);
    check(ramp_level, 17'h00000);
    wr(`RAMP_SET_OFFSET, 8'h80);
    settle(n);
    check(n >= 8189 && n <= 8198, 1'b1);
    check(ramp_level, 17'h10000);
  endtask : t_ramp
  task automatic t_comp;
    send(x, y, scl(x, g), scl(y, g));
    dsd_mode = 1'b1;
    send(x, y, scl(32'h20000000, g), scl(32'hE0000000, g));
    wr(`COMP_CTRL_OFFSET, 8'h00);
    send(x, y, scl(x, g), scl(y, g));
    dsd_mode = 1'b0;
    wr(`COEF2_HI_OFFSET, 8'h40);
    send(x, -x, scl(32'h50000000, g), scl(32'hD0000000, g));
    wr(`COEF2_HI_OFFSET, 8'h00);
    wr(`COEF3_HI_OFFSET, 8'hC0);
    send(x, -x, scl(32'h38000000, g), scl(32'hC8000000, g));
    wr(`COEF3_HI_OFFSET, 8'h00);
    wr(`COEF2_HI_OFFSET, 8'h7F);
    wr(`COEF2_LO_OFFSET, 8'hFF);
    send(32'h7FFFFFFF, 32'h7FFFFFFF, scl(32'h7FFFFFFF, g), scl(32'h7FFFFFFF, g));
    wr(`COEF2_HI_OFFSET, 8'h00);
    wr(`COEF2_LO_OFFSET, 8'h00);
    wr(`COMP_CTRL_OFFSET, 8'h40);
  endtask : t_comp
  task automatic t_trim;
    wr(`TRIM_B0_OFFSET, 8'h00);
    wr(`TRIM_B1_OFFSET, 8'h00);
    wr(`TRIM_B2_OFFSET, 8'h00);
    wr(`TRIM_B3_OFFSET, 8'h40);
    send(x, y, scl(x, 32'h40000000), scl(y, 32'h40000000));
    wr(`TRIM_B3_OFFSET, 8'hC0);
    send(x, y, scl(x, 32'hC0000000), scl(y, 32'hC0000000));
    for (int i = 0; i < 3; i++) wr(`TRIM_B0_OFFSET + 8'(i), 8'hFF);
    wr(`TRIM_B3_OFFSET, 8'h7F);
  endtask : t_trim
  task automatic t_atten;
    logic [7:0] d;
    sample_type e;
    logic signed [63:0] p;
    e = scl(x, g);
    p = 64'(e) * 64'sd30935;
    wr(`ATTEN_A_OFFSET, 8'h0C);
    rd(`ATTEN_A_OFFSET, d);
    check(d, 8'h0C);
    wr(`ATTEN_B_OFFSET, 8'h18);
    send(x, x, e >>> 1, e >>> 2);
    channel_swap = 1'b1;
    send(x, x, e >>> 2, e >>> 1);
    channel_swap = 1'b0;
    wr(`ATTEN_A_OFFSET, 8'h01);
    send(x, x, p[46:15], e >>> 2);
    wr(`ATTEN_A_OFFSET, 8'h00);
    wr(`ATTEN_B_OFFSET, 8'h00);
  endtask : t_atten
  task automatic t_lock;
    int n;
    wr(`RAMP_SET_OFFSET, 8'hA0);
    input_present = 1'b1;
    frc_run = 1'b1;
    repeat (3000) @(posedge ref_clk) #1;
    check(locked, 1'b0);
    check(muted, 1'b1);
    n = 0;
    while (locked !== 1'b1 && n < 3000) begin
      @(posedge ref_clk) #1;
      n++;
    end
    check(locked, 1'b1);
    repeat (2) @(posedge ref_clk) #1;
    check(muted, 1'b0);
    input_present = 1'b0;
    repeat (4) @(posedge ref_clk) #1;
    check(locked, 1'b0);
    check(muted, 1'b1);
    send(x, x, 32'h0, 32'h0);
    wr(`RAMP_SET_OFFSET, 8'hC0);
    settle(n);
    check(ramp_level, 17'h00000);
    check(muted, 1'b0);
  endtask : t_lock

  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_regs;
    t_ramp;
    t_comp;
    t_trim;
    t_atten;
    t_lock;
    give_verdict;
  end
  // Two full ramps and one lock take about 21000 cycles; nearly three times that means a hang.
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    give_verdict;
  end
endmodule : dac_output_gain_stage_tb_top
